//--- common/esq_pkg.sv
// Constants for the event status and queue block: bit positions, reset
// values, queue depths, flow-control levels and marker codes.
// Assumes a single 100 MHz clock and a synchronous, active-low reset.

package esq_pkg;
   // ==========================================================
   // Event status latch layout
   localparam int LATCH_W = 16;
   localparam int POS_POWER = 7;
   localparam int POS_MALFORMED = 5;
   localparam int POS_EXEC = 4;
   localparam int POS_DEVICE = 3;
   localparam int POS_QUERY = 2;
   localparam int POS_DONE = 0;
   localparam logic [15:0] LATCH_LIVE_BITS = 16'h00BD;
   localparam logic [15:0] LATCH_RST = 16'h0080;
   localparam logic [15:0] MASK_RST = 16'h0000;

   // ==========================================================
   // Queues
   localparam int OQ_DEPTH = 250;
   localparam int EQ_DEPTH = 16;
   localparam int EQ_KEEP = 15;
   localparam int ERR_W = 16;
   localparam logic [15:0] EQ_OVERFLOW_CODE = 16'h0001;
   localparam logic [15:0] EQ_EMPTY_CODE = 16'h0000;
   localparam int IB_DEPTH = 250;
   localparam int IB_W = 9;
   localparam logic [8:0] IB_EOI_MARK = 9'h100;

   // ==========================================================
   // Serial flow control levels and characters
   localparam int IB_CW = $clog2(IB_DEPTH + 1);
   localparam logic [IB_CW-1:0] IB_STOP_LVL = IB_CW'(IB_DEPTH * 80 / 100);
   localparam logic [IB_CW-1:0] IB_GO_LVL = IB_CW'(IB_DEPTH * 40 / 100);
   localparam logic [7:0] XOFF_CHAR = 8'h13;
   localparam logic [7:0] XON_CHAR = 8'h11;

   // ==========================================================
   // Pin synchroniser width
   localparam int SYNC_BITS = 10;
endpackage

//--- hw/esq_fifo.sv
// Synchronous first-in first-out store with clear, count, full and empty.
// Assumes push is never asked while full unless the caller accepts a drop.
`timescale 1ns/1ps
module esq_fifo
   import esq_pkg::*;
#(
   parameter int W = 8,
   parameter int D = 4
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // Control
   input wire logic clr,
   input wire logic push,
   input wire logic [W-1:0] din,
   input wire logic pop,
   // State
   output logic [W-1:0] dout,
   output logic [$clog2(D+1)-1:0] count,
   output logic full,
   output logic empty
);
   localparam int AW = $clog2(D);
   localparam int CW = $clog2(D + 1);

   logic [W-1:0] mem_q [D];
   logic [AW-1:0] wp_q;
   logic [AW-1:0] rp_q;
   logic [CW-1:0] cnt_q;

   // Accepted moves and wrapped pointers
   wire do_push = push && !full;
   wire do_pop = pop && !empty;
   wire [AW-1:0] wp_nx = (wp_q == AW'(D - 1)) ? '0 : wp_q + 1'b1;
   wire [AW-1:0] rp_nx = (rp_q == AW'(D - 1)) ? '0 : rp_q + 1'b1;

   assign full = (cnt_q == CW'(D));
   assign empty = (cnt_q == '0);
   assign count = cnt_q;
   assign dout = mem_q[rp_q];

   // Storage array
   always_ff @(posedge ref_clk) begin
      if (do_push) begin
         mem_q[wp_q] <= din;
      end
   end

   // Pointers and fill count
   always_ff @(posedge ref_clk) begin
      if (!rstn || clr) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end else begin
         if (do_push) wp_q <= wp_nx;
         if (do_pop) rp_q <= rp_nx;
         if (do_push && !do_pop) cnt_q <= cnt_q + 1'b1;
         else if (do_pop && !do_push) cnt_q <= cnt_q - 1'b1;
      end
   end
endmodule

//--- hw/esq_top.sv
// Event status latch, mask, output queue, error queue and input buffer
// with parallel-bus acceptor handshake and serial flow control.
// Assumes a command parser on the same clock drives the strobes, and
// that parallel-bus pins arrive asynchronously.
`timescale 1ns/1ps
module esq_top
   import esq_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // Status commands from the parser
   input wire logic latch_rd,
   input wire logic mask_rd,
   input wire logic mask_wr,
   input wire logic [15:0] mask_wdata,
   input wire logic clr_status,
   input wire logic dev_clr,
   input wire logic rst_cmd,
   output logic [15:0] status_reply,
   output logic status_reply_valid,
   output logic event_summary_bit,
   // Events
   input wire logic malformed_evt,
   input wire logic exec_fault_evt,
   input wire logic device_fault_evt,
   input wire logic query_fault_evt,
   input wire logic [15:0] err_code,
   input wire logic done_arm,
   input wire logic ops_idle,
   // Error queue read
   input wire logic err_rd,
   output logic [15:0] err_reply,
   output logic err_reply_valid,
   // Output queue
   input wire logic oq_wr,
   input wire logic [7:0] oq_wdata,
   input wire logic oq_rd,
   output logic [7:0] oq_rdata,
   output logic oq_rdata_valid,
   output logic reply_pending_bit,
   // Input buffer toward the parser
   input wire logic ib_ready,
   output logic ib_valid,
   output logic [8:0] ib_data,
   // Serial receive and flow control
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic flow_en,
   output logic flow_tx_valid,
   output logic [7:0] flow_tx_char,
   // Parallel bus pins, active low
   input wire logic dav_n_i,
   input wire logic eoi_n_i,
   input wire logic [7:0] dio_n_i,
   output logic nrfd_n_o,
   output logic nrfd_oe,
   output logic ndac_n_o,
   output logic ndac_oe
);
   typedef enum logic [1:0] {AC_IDLE, AC_EOI, AC_RELEASE} esq_acc_t;

   // ==========================================================
   // Pin synchronisers
   logic [SYNC_BITS-1:0] s1_q, s2_q, s3_q, pin_q;
   wire [SYNC_BITS-1:0] pin_raw = {dav_n_i, eoi_n_i, dio_n_i};

   genvar gi;
   generate
      for (gi = 0; gi < SYNC_BITS; gi++) begin : g_sync
         // Three stages; the value moves only once stages two and three agree
         always_ff @(posedge ref_clk) begin
            if (!rstn) begin
               s1_q[gi] <= 1'b1;
               s2_q[gi] <= 1'b1;
               s3_q[gi] <= 1'b1;
               pin_q[gi] <= 1'b1;
            end else begin
               s1_q[gi] <= pin_raw[gi];
               s2_q[gi] <= s1_q[gi];
               s3_q[gi] <= s2_q[gi];
               if (s2_q[gi] == s3_q[gi]) pin_q[gi] <= s3_q[gi];
            end
         end
      end
   endgenerate

   wire dav_act = !pin_q[9];
   wire eoi_act = !pin_q[8];
   wire [7:0] dio_byte = ~pin_q[7:0];

   // ==========================================================
   // Output queue
   logic [7:0] oq_dout;
   logic [7:0] oq_count;
   logic oq_full, oq_empty;
   wire oq_clr = dev_clr;
   wire oq_pop = oq_rd && !oq_empty;

   // Replies queue up; host reads remove characters
   esq_fifo #(.W(8), .D(OQ_DEPTH)) u_oq (
      .ref_clk(ref_clk), .rstn(rstn), .clr(oq_clr),
      .push(oq_wr), .din(oq_wdata), .pop(oq_pop),
      .dout(oq_dout), .count(oq_count), .full(oq_full), .empty(oq_empty)
   );

   assign reply_pending_bit = !oq_empty;

   // Host read: data only when queue holds something
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         oq_rdata <= 8'h00;
         oq_rdata_valid <= 1'b0;
      end else begin
         oq_rdata_valid <= oq_pop;
         if (oq_pop) oq_rdata <= oq_dout;
      end
   end

   // ==========================================================
   // Error queue
   logic [15:0] eq_dout;
   logic [4:0] eq_count;
   logic eq_full, eq_empty;
   wire eq_evt = malformed_evt || exec_fault_evt || device_fault_evt;
   wire eq_push = eq_evt && !eq_full;
   wire [15:0] eq_din = (eq_count >= 5'(EQ_KEEP)) ? EQ_OVERFLOW_CODE : err_code;
   wire eq_pop = err_rd && !eq_empty;

   // Error codes queue in order of arrival
   esq_fifo #(.W(ERR_W), .D(EQ_DEPTH)) u_eq (
      .ref_clk(ref_clk), .rstn(rstn), .clr(clr_status),
      .push(eq_push), .din(eq_din), .pop(eq_pop),
      .dout(eq_dout), .count(eq_count), .full(eq_full), .empty(eq_empty)
   );

   // Error read answer, zero when nothing is queued
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         err_reply <= EQ_EMPTY_CODE;
         err_reply_valid <= 1'b0;
      end else begin
         err_reply_valid <= err_rd;
         if (err_rd) err_reply <= eq_empty ? EQ_EMPTY_CODE : eq_dout;
      end
   end

   // ==========================================================
   // Input buffer
   logic [8:0] ib_dout;
   logic [IB_CW-1:0] ib_count;
   logic ib_full, ib_empty;
   logic gp_push;
   logic [8:0] gp_byte;
   wire rx_push = rx_valid;
   wire ib_push = rx_push || gp_push;
   wire [8:0] ib_din = rx_push ? {1'b0, rx_data} : gp_byte;
   wire ib_pop = ib_ready && !ib_empty;

   // Host bytes in arrival order; cleared on device clear
   esq_fifo #(.W(IB_W), .D(IB_DEPTH)) u_ib (
      .ref_clk(ref_clk), .rstn(rstn), .clr(dev_clr),
      .push(ib_push), .din(ib_din), .pop(ib_pop),
      .dout(ib_dout), .count(ib_count), .full(ib_full), .empty(ib_empty)
   );

   assign ib_valid = !ib_empty;
   assign ib_data = ib_dout;

   // ==========================================================
   // Parallel bus acceptor
   esq_acc_t acc_q, acc_d;
   wire room = !ib_full && !rx_valid;

   // Next state and the byte to store
   always_comb begin
      acc_d = acc_q;
      gp_push = 1'b0;
      gp_byte = {1'b0, dio_byte};
      case (acc_q)
         AC_IDLE: begin
            if (dav_act && room) begin
               gp_push = 1'b1;
               acc_d = eoi_act ? AC_EOI : AC_RELEASE;
            end
         end
         AC_EOI: begin
            gp_byte = IB_EOI_MARK;
            if (room) begin
               gp_push = 1'b1;
               acc_d = AC_RELEASE;
            end
         end
         AC_RELEASE: begin
            if (!dav_act) acc_d = AC_IDLE;
         end
         default: acc_d = AC_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn || dev_clr) acc_q <= AC_IDLE;
      else acc_q <= acc_d;
   end

   // Hold not-ready while full or while a byte is being taken
   assign nrfd_n_o = 1'b0;
   assign nrfd_oe = (acc_q != AC_IDLE) || ib_full;
   assign ndac_n_o = 1'b0;
   assign ndac_oe = (acc_q != AC_RELEASE);

   // ==========================================================
   // Serial flow control
   logic stopped_q;

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         stopped_q <= 1'b0;
         flow_tx_valid <= 1'b0;
         flow_tx_char <= XON_CHAR;
      end else begin
         flow_tx_valid <= 1'b0;
         if (flow_en && !stopped_q && ib_count >= IB_STOP_LVL) begin
            stopped_q <= 1'b1;
            flow_tx_valid <= 1'b1;
            flow_tx_char <= XOFF_CHAR;
         end else if (stopped_q && ib_count < IB_GO_LVL) begin
            stopped_q <= 1'b0;
            flow_tx_valid <= 1'b1;
            flow_tx_char <= XON_CHAR;
         end
      end
   end

   // ==========================================================
   // Event status latch and mask
   logic [15:0] latch_q, latch_d, mask_q, set_vec;
   logic done_arm_q;
   wire latch_clr = latch_rd || clr_status || dev_clr || rst_cmd;
   wire query_set = query_fault_evt || (oq_rd && oq_empty) || (oq_wr && oq_full);
   wire done_set = done_arm_q && ops_idle && !ib_full;

   // Event sources to latch bits
   always_comb begin
      set_vec = 16'h0000;
      set_vec[POS_MALFORMED] = malformed_evt;
      set_vec[POS_EXEC] = exec_fault_evt;
      set_vec[POS_DEVICE] = device_fault_evt;
      set_vec[POS_QUERY] = query_set;
      set_vec[POS_DONE] = done_set;
   end

   // New events win over a clear in the same cycle
   assign latch_d = ((latch_clr ? 16'h0000 : latch_q) | set_vec) & LATCH_LIVE_BITS;

   always_ff @(posedge ref_clk) begin
      if (!rstn) latch_q <= LATCH_RST;
      else latch_q <= latch_d;
   end

   // Mask write; reads leave it alone
   always_ff @(posedge ref_clk) begin
      if (!rstn) mask_q <= MASK_RST;
      else if (mask_wr) mask_q <= mask_wdata & LATCH_LIVE_BITS;
   end

   // Pending done request; clear-status and resets drop it
   always_ff @(posedge ref_clk) begin
      if (!rstn || clr_status || dev_clr || rst_cmd) done_arm_q <= 1'b0;
      else if (done_arm) done_arm_q <= 1'b1;
      else if (done_set) done_arm_q <= 1'b0;
   end

   assign event_summary_bit = |(latch_q & mask_q);

   // Status read answer, whole 16-bit value
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         status_reply <= 16'h0000;
         status_reply_valid <= 1'b0;
      end else begin
         status_reply_valid <= latch_rd || mask_rd;
         if (latch_rd) status_reply <= latch_q;
         else if (mask_rd) status_reply <= mask_q;
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   sequence take_byte_s;
      (acc_q == AC_IDLE) && dav_act && room;
   endsequence

   sequence release_s;
      !nrfd_n_o && nrfd_oe && !ndac_oe;
   endsequence

   pad_bits_zero_a: assert property ((latch_q & ~LATCH_LIVE_BITS) == 16'h0000)
      else $error("latch reserved bit set");
   power_after_reset_a: assert property ($rose(rstn) |-> latch_q[POS_POWER])
      else $error("power flag missing after reset");
   malformed_set_a: assert property (malformed_evt |=> latch_q[POS_MALFORMED])
      else $error("malformed flag not set");
   exec_set_a: assert property (exec_fault_evt |=> latch_q[POS_EXEC])
      else $error("execution flag not set");
   read_clears_a: assert property (latch_rd && set_vec == 16'h0000 |=> latch_q == 16'h0000
      && status_reply == $past(latch_q)) else $error("latch read did not clear");
   mask_read_keeps_a: assert property (mask_rd && !mask_wr |=> $stable(mask_q))
      else $error("mask changed on read");
   pending_tracks_queue_a: assert property (reply_pending_bit == (oq_count != 8'h00))
      else $error("reply pending bit wrong");
   empty_err_zero_a: assert property (err_rd && eq_empty |=> err_reply_valid
      && err_reply == EQ_EMPTY_CODE) else $error("empty error read not zero");
   overflow_entry_a: assert property (eq_evt && eq_count == 5'(EQ_KEEP) && !eq_pop
      |=> eq_full) else $error("overflow entry not stored");
   full_holds_a: assert property (ib_full |-> nrfd_oe)
      else $error("not-ready released while full");
   byte_then_release_a: assert property ((take_byte_s and !eoi_act) |=> release_s)
      else $error("handshake did not move to release");
   stop_sent_a: assert property (flow_en && !stopped_q && ib_count >= IB_STOP_LVL
      |=> flow_tx_valid && flow_tx_char == XOFF_CHAR) else $error("stop char not sent");
   summary_a: assert property (event_summary_bit == ((latch_q & mask_q) != 16'h0000))
      else $error("summary bit wrong");
   read_keeps_new_a: assert property (latch_rd && malformed_evt |=> latch_q[POS_MALFORMED])
      else $error("event lost on read");
endmodule

//--- verification/esq_host_model.sv
// Remote host model: parallel-bus talker and serial byte sender.
// Assumes the device pins of esq_top and one shared clock.
`timescale 1ns/1ps
module esq_host_model
   import esq_pkg::*;
(
   // Clock
   input wire logic ref_clk,
   // Device outputs seen by the host
   input wire logic nrfd_oe,
   input wire logic ndac_oe,
   input wire logic flow_tx_valid,
   input wire logic [7:0] flow_tx_char,
   // Host drive
   output logic dav_n_i,
   output logic eoi_n_i,
   output logic [7:0] dio_n_i,
   output logic rx_valid,
   output logic [7:0] rx_data
);
   // ==========================================================
   // Idle bus: pulled-up lines read high
   logic paused_q = 1'b0;
   initial begin
      dav_n_i = 1'b1;
      eoi_n_i = 1'b1;
      dio_n_i = 8'hFF;
      rx_valid = 1'b0;
      rx_data = 8'h00;
   end

   // Stop characters pause the serial sender and start characters resume it
   always @(posedge ref_clk) begin
      if (flow_tx_valid === 1'b1) begin
         paused_q <= (flow_tx_char == XOFF_CHAR);
      end
   end

   // ==========================================================
   // One three-wire handshake; waits while the device holds off
   task par_send(input logic [7:0] b, input logic last);
      @(negedge ref_clk);
      while (nrfd_oe !== 1'b0) @(negedge ref_clk);
      dio_n_i = ~b;
      eoi_n_i = ~last;
      dav_n_i = 1'b0;
      while (ndac_oe !== 1'b0) @(negedge ref_clk);
      dav_n_i = 1'b1;
      eoi_n_i = 1'b1;
      dio_n_i = 8'hFF;
      while (ndac_oe !== 1'b1) @(negedge ref_clk);
   endtask

   // One serial byte; held back while paused
   task ser_send(input logic [7:0] b);
      @(negedge ref_clk);
      while (paused_q) @(negedge ref_clk);
      rx_valid = 1'b1;
      rx_data = b;
      @(negedge ref_clk);
      rx_valid = 1'b0;
      rx_data = ~b;
   endtask
endmodule

//--- verification/event_status_and_queues_tb_top.sv
// Self-checking bench for esq_top with the host model on its pins.
// Assumes a 100 MHz clock; inputs change on the falling edge.
`timescale 1ns/1ps
module event_status_and_queues_tb_top
   import esq_pkg::*;
;
   // ==========================================================
   // Design signals
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   logic [13:0] strb = 14'h0000;
   logic latch_rd, mask_rd, mask_wr, clr_status, dev_clr, rst_cmd;
   logic malformed_evt, exec_fault_evt, device_fault_evt, query_fault_evt;
   logic done_arm, err_rd, oq_wr, oq_rd;
   logic [15:0] mask_wdata = 16'h0000;
   logic [15:0] err_code = 16'h0000;
   logic ops_idle = 1'b0;
   logic [7:0] oq_wdata = 8'h00;
   logic ib_ready = 1'b0;
   logic flow_en = 1'b0;
   logic [15:0] status_reply, err_reply;
   logic status_reply_valid, event_summary_bit, err_reply_valid;
   logic [7:0] oq_rdata, rx_data, flow_tx_char, dio_n_i;
   logic oq_rdata_valid, reply_pending_bit, ib_valid, rx_valid, flow_tx_valid;
   logic [8:0] ib_data;
   logic dav_n_i, eoi_n_i, nrfd_n_o, nrfd_oe, ndac_n_o, ndac_oe;
   int err_total = 0;
   int n_compared = 0;
   int cyc = 0;
   int n_flow = 0;
   logic [7:0] last_flow = 8'h00;
   logic [8:0] exp_q[$];
   localparam logic [13:0] S_LRD = 14'h2000, S_MRD = 14'h1000, S_MWR = 14'h0800;
   localparam logic [13:0] S_CLS = 14'h0400, S_DCL = 14'h0200, S_RST = 14'h0100;
   localparam logic [13:0] S_MAL = 14'h0080, S_EXE = 14'h0040, S_DEV = 14'h0020;
   localparam logic [13:0] S_QRY = 14'h0010, S_ARM = 14'h0008, S_ERD = 14'h0004;
   localparam logic [13:0] S_OWR = 14'h0002, S_ORD = 14'h0001;
   // Rows: ops_idle and strobe in, latch and error reply out
   logic [14:0] row_in [6] = '{15'h0080, 15'h0040, 15'h0020, 15'h0010, 15'h0008, 15'h4000};
   logic [15:0] row_lat [6] = '{16'h0020, 16'h0010, 16'h0008, 16'h0004, 16'h0000, 16'h0001};
   logic [15:0] row_err [6] = '{16'h0101, 16'h0102, 16'h0103, 16'h0000, 16'h0000, 16'h0000};

   // Strobe vector fans out to the command pulses
   assign {latch_rd, mask_rd, mask_wr, clr_status, dev_clr, rst_cmd, malformed_evt,
      exec_fault_evt, device_fault_evt, query_fault_evt, done_arm, err_rd, oq_wr, oq_rd} = strb;

   esq_top DUT (.ref_clk(ref_clk), .rstn(rstn), .latch_rd(latch_rd), .mask_rd(mask_rd),
      .mask_wr(mask_wr), .mask_wdata(mask_wdata), .clr_status(clr_status), .dev_clr(dev_clr),
      .rst_cmd(rst_cmd), .status_reply(status_reply), .status_reply_valid(status_reply_valid),
      .event_summary_bit(event_summary_bit), .malformed_evt(malformed_evt),
      .exec_fault_evt(exec_fault_evt), .device_fault_evt(device_fault_evt),
      .query_fault_evt(query_fault_evt), .err_code(err_code), .done_arm(done_arm),
      .ops_idle(ops_idle), .err_rd(err_rd), .err_reply(err_reply),
      .err_reply_valid(err_reply_valid), .oq_wr(oq_wr), .oq_wdata(oq_wdata), .oq_rd(oq_rd),
      .oq_rdata(oq_rdata), .oq_rdata_valid(oq_rdata_valid),
      .reply_pending_bit(reply_pending_bit), .ib_ready(ib_ready), .ib_valid(ib_valid),
      .ib_data(ib_data), .rx_valid(rx_valid), .rx_data(rx_data), .flow_en(flow_en),
      .flow_tx_valid(flow_tx_valid), .flow_tx_char(flow_tx_char), .dav_n_i(dav_n_i),
      .eoi_n_i(eoi_n_i), .dio_n_i(dio_n_i), .nrfd_n_o(nrfd_n_o), .nrfd_oe(nrfd_oe),
      .ndac_n_o(ndac_n_o), .ndac_oe(ndac_oe));

   esq_host_model HOST (.ref_clk(ref_clk), .nrfd_oe(nrfd_oe), .ndac_oe(ndac_oe),
      .flow_tx_valid(flow_tx_valid), .flow_tx_char(flow_tx_char), .dav_n_i(dav_n_i),
      .eoi_n_i(eoi_n_i), .dio_n_i(dio_n_i), .rx_valid(rx_valid), .rx_data(rx_data));

   // ==========================================================
   // Clock, cycle ceiling and flow character monitor
   always #5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cyc++;
      if (flow_tx_valid === 1'b1) begin
         n_flow++;
         last_flow = flow_tx_char;
      end
      if (cyc == 20000) begin
         err_total++;
         close_out();
      end
   end

   // ==========================================================
   // Shared tasks
   task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task st(input logic [13:0] s);
      @(negedge ref_clk);
      strb = s;
      @(negedge ref_clk);
      strb = 14'h0000;
   endtask
   task rd_stat(input logic [13:0] s, input logic [15:0] exp);
      // Reply and its one-cycle valid stand at the falling edge where st returns
      st(s);
      chk("status_reply_valid", 16'h0001, {15'h0000, status_reply_valid});
      chk("status_reply", exp, status_reply);
   endtask
   task rd_err(input logic [15:0] exp);
      st(S_ERD);
      chk("err_reply_valid", 16'h0001, {15'h0000, err_reply_valid});
      chk("err_reply", exp, err_reply);
   endtask
   task ser(input logic [7:0] b);
      exp_q.push_back({1'b0, b});
      HOST.ser_send(b);
   endtask
   task par(input logic [7:0] b, input logic last);
      // The data byte is stored first, the end marker right behind it
      exp_q.push_back({1'b0, b});
      if (last) exp_q.push_back(IB_EOI_MARK);
      HOST.par_send(b, last);
   endtask
   task drain(input int n);
      int k;
      for (int i = 0; i < n; i++) begin
         @(negedge ref_clk);
         k = 0;
         while (ib_valid !== 1'b1 && k < 50) begin
            @(negedge ref_clk);
            k++;
         end
         chk("ib_data", {7'h00, exp_q.pop_front()}, {7'h00, ib_data});
         ib_ready = 1'b1;
      end
      @(negedge ref_clk);
      ib_ready = 1'b0;
   endtask
   task fin(input string name);
      $display("test %s done, mismatches so far %0d", name, err_total);
   endtask
   task close_out();
      $display("compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      repeat (16) @(negedge ref_clk);
      rstn = 1'b1;
      chk("event_summary_bit", 16'h0000, {15'h0000, event_summary_bit});
      mask_wdata = 16'hFFFF;
      st(S_MWR);
      chk("event_summary_bit", 16'h0001, {15'h0000, event_summary_bit});
      rd_stat(S_MRD, LATCH_LIVE_BITS);
      rd_stat(S_MRD, LATCH_LIVE_BITS);
      rd_stat(S_LRD, 16'h0080);
      rd_stat(S_LRD, 16'h0000);
      fin("reset and mask");
      for (int i = 0; i < 6; i++) begin
         ops_idle = row_in[i][14];
         err_code = 16'h0101 + 16'(i);
         st(row_in[i][13:0]);
         repeat (3) @(negedge ref_clk);
         chk("event_summary_bit", {15'h0000, row_lat[i] != 0}, {15'h0000, event_summary_bit});
         rd_stat(S_LRD, row_lat[i]);
         rd_err(row_err[i]);
      end
      ops_idle = 1'b0;
      fin("event rows");
      err_code = 16'h0400;
      rd_stat(S_LRD | S_MAL, 16'h0000);
      rd_stat(S_LRD, 16'h0020);
      st(S_EXE);
      st(S_RST);
      rd_stat(S_LRD, 16'h0000);
      fin("read collision and reset");
      st(S_CLS);
      for (int i = 0; i < 17; i++) begin
         err_code = 16'h0200 + 16'(i);
         st(S_MAL);
      end
      for (int i = 0; i < EQ_KEEP; i++) rd_err(16'h0200 + 16'(i));
      rd_err(EQ_OVERFLOW_CODE);
      rd_err(EQ_EMPTY_CODE);
      st(S_EXE);
      st(S_CLS);
      rd_err(EQ_EMPTY_CODE);
      rd_stat(S_LRD, 16'h0000);
      fin("error queue");
      chk("reply_pending_bit", 16'h0000, {15'h0000, reply_pending_bit});
      st(S_ORD);
      chk("oq_rdata_valid", 16'h0000, {15'h0000, oq_rdata_valid});
      rd_stat(S_LRD, 16'h0004);
      for (int i = 0; i <= OQ_DEPTH; i++) begin
         oq_wdata = (i == OQ_DEPTH) ? 8'hEE : i[7:0];
         st(S_OWR);
      end
      chk("reply_pending_bit", 16'h0001, {15'h0000, reply_pending_bit});
      for (int i = 0; i < OQ_DEPTH; i++) begin
         st(S_ORD);
         chk("oq_rdata_valid", 16'h0001, {15'h0000, oq_rdata_valid});
         chk("oq_rdata", {8'h00, i[7:0]}, {8'h00, oq_rdata});
      end
      chk("reply_pending_bit", 16'h0000, {15'h0000, reply_pending_bit});
      rd_stat(S_LRD, 16'h0004);
      fin("output queue");
      par(8'h41, 1'b0);
      par(8'h0A, 1'b1);
      drain(3);
      flow_en = 1'b1;
      for (int i = 0; i < int'(IB_STOP_LVL); i++) begin
         if (i == int'(IB_STOP_LVL) - 1) begin
            repeat (4) @(negedge ref_clk);
            chk("flow count", 16'h0000, 16'(n_flow));
         end
         ser(i[7:0]);
      end
      repeat (4) @(negedge ref_clk);
      chk("flow count", 16'h0001, 16'(n_flow));
      chk("flow char", {8'h00, XOFF_CHAR}, {8'h00, last_flow});
      drain(int'(IB_STOP_LVL) - int'(IB_GO_LVL));
      repeat (4) @(negedge ref_clk);
      chk("flow count", 16'h0001, 16'(n_flow));
      drain(1);
      repeat (4) @(negedge ref_clk);
      chk("flow char", {8'h00, XON_CHAR}, {8'h00, last_flow});
      flow_en = 1'b0;
      while (exp_q.size() < IB_DEPTH) ser(8'h80 + 8'(exp_q.size()));
      repeat (4) @(negedge ref_clk);
      chk("nrfd_oe", 16'h0001, {15'h0000, nrfd_oe});
      chk("nrfd_n_o", 16'h0000, {15'h0000, nrfd_n_o});
      chk("ndac_n_o", 16'h0000, {15'h0000, ndac_n_o});
      fork
         par(8'h5A, 1'b0);
      join_none
      repeat (20) @(negedge ref_clk);
      chk("ndac_oe", 16'h0001, {15'h0000, ndac_oe});
      drain(1);
      repeat (40) @(negedge ref_clk);
      chk("nrfd_oe", 16'h0001, {15'h0000, nrfd_oe});
      drain(IB_DEPTH);
      fin("input buffer");
      ser(8'h01);
      oq_wdata = 8'h33;
      st(S_OWR);
      st(S_QRY);
      st(S_DCL);
      exp_q.delete();
      @(negedge ref_clk);
      chk("ib_valid", 16'h0000, {15'h0000, ib_valid});
      chk("reply_pending_bit", 16'h0000, {15'h0000, reply_pending_bit});
      rd_stat(S_LRD, 16'h0000);
      fin("device clear");
      close_out();
   end
endmodule
